// *** shared/pdld_pkg.sv ***
package pdld_pkg;
  localparam int R_W = 10;
  localparam int N_W = 17;
  localparam int A_W = 4;
  localparam int B_W = 13;
  localparam int CP_W = 2;
  localparam int CUR_W = 3;
  localparam logic [R_W-1:0] R_MIN = 10'h004;
  localparam logic [R_W-1:0] R_ONE = 10'h001;
  localparam logic [B_W-1:0] B_MIN = 13'h0004;
  localparam logic [B_W-1:0] B_ONE = 13'h0001;
  localparam logic [A_W-1:0] A_ONE = 4'h1;
  localparam logic [4:0] PRE_HI_MOD = 5'h11;
  localparam logic [4:0] PRE_LO_MOD = 5'h10;
  localparam logic [4:0] PRE_ONE = 5'h01;
  // Pin positions inside the synchroniser vectors
  localparam int PIN_CNT = 6;
  localparam int PIN_REF = 0;
  localparam int PIN_VCO = 1;
  localparam int PIN_UP = 2;
  localparam int PIN_DN = 3;
  localparam int PIN_FS0 = 4;
  localparam int PIN_FS1 = 5;
  localparam logic [1:0] ARM_CAP = 2'h2;
  localparam logic [1:0] ARM_DONE = 2'h3;
  typedef enum logic [2:0] {
    PDLD_STANDBY = 3'h0,
    PDLD_RX = 3'h1,
    PDLD_TX = 3'h2,
    PDLD_OSC_IDLE = 3'h3,
    PDLD_PLL_IDLE = 3'h4
  } pdld_mode_t;
  // Stand-alone presets, indexed by {fs1, fs0}
  localparam logic [3:0][R_W-1:0] SA_REF = {10'h020, 10'h020, 10'h020, 10'h020};
  localparam logic [3:0][N_W-1:0] SA_FB = {17'h00E4C, 17'h00D8F, 17'h006C7, 17'h004EC};
  localparam logic [CP_W-1:0] DEF_PUMP = 2'h3;
  localparam logic DEF_POL = 1'b0;
  localparam logic [CUR_W-1:0] DEF_OSC_START = 3'h7;
  localparam logic [CUR_W-1:0] DEF_OSC_STEADY = 3'h2;
  localparam logic [CUR_W-1:0] DEF_VCO = 3'h3;
  localparam logic [15:0] DEF_LOCK_TIME = 16'h0010;
  localparam logic [15:0] DEF_ERR_TIME = 16'h0004;
  localparam logic DEF_LATCH = 1'b1;
endpackage : pdld_pkg

// *** logic/pdld_ref_div.sv ***
module pdld_ref_div
  import pdld_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ref_tick,
  input wire logic restart,
  input wire logic [R_W-1:0] ref_div,
  output logic ref_pulse
);
  typedef struct packed {
    logic [R_W-1:0] cnt_ff;
    logic pulse_ff;
  } pdld_rd_t;
  pdld_rd_t st_ff;
  pdld_rd_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pulse_ff = 1'b0;
    if (restart) begin
      nxt_st.cnt_ff = ref_div;
    end else if (ref_tick) begin
      if (st_ff.cnt_ff <= R_ONE) begin
        nxt_st.cnt_ff = ref_div;
        nxt_st.pulse_ff = 1'b1;
      end else begin
        nxt_st.cnt_ff = st_ff.cnt_ff - R_ONE;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ref_pulse = st_ff.pulse_ff;

  ref_terminal_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.pulse_ff |-> $past(ref_tick) && $past(st_ff.cnt_ff) <= R_ONE && !$past(restart))
    else $error("comparison pulse without terminal count");
endmodule : pdld_ref_div

// *** logic/pdld_fb_div.sv ***
module pdld_fb_div
  import pdld_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic vco_tick,
  input wire logic restart,
  input wire logic [N_W-1:0] ratio,
  output logic fb_pulse
);
  typedef struct packed {
    logic [4:0] pre_ff;
    logic [A_W-1:0] a_ff;
    logic [B_W-1:0] b_ff;
    logic pulse_ff;
  } pdld_fb_t;
  pdld_fb_t st_ff;
  pdld_fb_t nxt_st;
  logic [4:0] modulus;

  // Swallow phase divides by the high modulus, then the low one
  assign modulus = (st_ff.a_ff != '0) ? PRE_HI_MOD : PRE_LO_MOD;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pulse_ff = 1'b0;
    if (restart) begin
      nxt_st.pre_ff = '0;
      nxt_st.a_ff = ratio[A_W-1:0];
      nxt_st.b_ff = ratio[N_W-1:A_W];
    end else if (vco_tick) begin
      if (st_ff.pre_ff == modulus - PRE_ONE) begin
        nxt_st.pre_ff = '0;
        if (st_ff.b_ff <= B_ONE) begin
          nxt_st.a_ff = ratio[A_W-1:0];
          nxt_st.b_ff = ratio[N_W-1:A_W];
          nxt_st.pulse_ff = 1'b1;
        end else begin
          nxt_st.b_ff = st_ff.b_ff - B_ONE;
          if (st_ff.a_ff != '0) begin
            nxt_st.a_ff = st_ff.a_ff - A_ONE;
          end
        end
      end else begin
        nxt_st.pre_ff = st_ff.pre_ff + PRE_ONE;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fb_pulse = st_ff.pulse_ff;

  swallow_modulus_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (vco_tick && !restart && st_ff.a_ff != '0 && st_ff.pre_ff == PRE_LO_MOD - PRE_ONE)
    |=> st_ff.pre_ff == PRE_LO_MOD)
    else $error("prescaler left the high modulus early");
  fb_terminal_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.pulse_ff |-> $past(vco_tick) && $past(st_ff.b_ff) <= B_ONE)
    else $error("feedback pulse without program count end");
endmodule : pdld_fb_div

// *** logic/pdld_synth.sv ***
module pdld_synth
  import pdld_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ref_osc_clk,
  input wire logic vco_fb_clk,
  input wire logic pd_up,
  input wire logic pd_down,
  input wire logic freq_sel0_serial_enable_pin,
  input wire logic freq_sel1_lock_pin_level,
  input wire logic [2:0] operating_mode_sel,
  input wire logic settings_wr,
  input wire logic [R_W-1:0] rx_ref_divider,
  input wire logic [N_W-1:0] rx_feedback_ratio,
  input wire logic [R_W-1:0] tx_ref_divider,
  input wire logic [N_W-1:0] tx_feedback_ratio,
  input wire logic [CP_W-1:0] pump_current_sel,
  input wire logic detector_polarity_bit,
  input wire logic [CNT_W-1:0] lock_time_count,
  input wire logic [CNT_W-1:0] error_time_count,
  input wire logic lock_latch_sel,
  input wire logic [CUR_W-1:0] osc_startup_current,
  input wire logic [CUR_W-1:0] osc_steady_current,
  input wire logic [CUR_W-1:0] vco_current_sel,
  output logic ref_cmp_pulse,
  output logic fb_cmp_pulse,
  output logic programmable_mode,
  output logic lock_indication,
  output logic freq_sel1_lock_pin,
  output logic freq_sel1_lock_pin_oe,
  output logic [CP_W-1:0] pump_current,
  output logic detector_polarity,
  output logic [CUR_W-1:0] osc_start_cur,
  output logic [CUR_W-1:0] osc_steady_cur,
  output logic amp_reg_en,
  output logic [CUR_W-1:0] vco_current,
  output logic setting_invalid
);
  if (CNT_W < 2 || CNT_W > 16) begin : g_cnt_chk
    $error("CNT_W must lie between 2 and 16");
  end

  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [PIN_CNT-1:0] sync1_ff;
    logic [PIN_CNT-1:0] sync2_ff;
    logic [PIN_CNT-1:0] prev_ff;
    logic [1:0] arm_ff;
    logic fs0_ref_ff;
    logic prog_ff;
    logic [R_W-1:0] rx_ref_ff;
    logic [N_W-1:0] rx_n_ff;
    logic [R_W-1:0] tx_ref_ff;
    logic [N_W-1:0] tx_n_ff;
    pdld_mode_t mode_ff;
    logic last_tx_ff;
    logic restart_ff;
    logic [CNT_W-1:0] lock_cnt_ff;
    logic [CNT_W-1:0] err_cnt_ff;
    logic lock_ind_ff;
    logic pin_out_ff;
    logic pin_oe_ff;
    logic [CP_W-1:0] pump_ff;
    logic pol_ff;
    logic [CUR_W-1:0] osc_start_ff;
    logic [CUR_W-1:0] osc_steady_ff;
    logic amp_reg_ff;
    logic [CUR_W-1:0] vco_cur_ff;
    logic invalid_ff;
  } pdld_st_t;
  pdld_st_t st_ff;
  pdld_st_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // Undefined mode codes behave as standby
  function automatic pdld_mode_t decode_mode(input logic [2:0] code);
    pdld_mode_t res;
    unique case (code)
      PDLD_RX: res = PDLD_RX;
      PDLD_TX: res = PDLD_TX;
      PDLD_OSC_IDLE: res = PDLD_OSC_IDLE;
      PDLD_PLL_IDLE: res = PDLD_PLL_IDLE;
      default: res = PDLD_STANDBY;
    endcase
    return res;
  endfunction : decode_mode

  function automatic logic pll_on(input pdld_mode_t md);
    return md == PDLD_RX || md == PDLD_TX || md == PDLD_PLL_IDLE;
  endfunction : pll_on

  function automatic logic ratio_ok(input logic [R_W-1:0] r, input logic [N_W-1:0] n);
    logic [B_W-1:0] b;
    logic [A_W-1:0] a;
    b = n[N_W-1:A_W];
    a = n[A_W-1:0];
    return r >= R_MIN && b >= B_MIN && b > B_W'(a);
  endfunction : ratio_ok

  ////////////////////////////////////////////////////////////////////////////
  logic [PIN_CNT-1:0] pins;
  logic [PIN_CNT-1:0] tick;
  pdld_mode_t mode_w;
  logic use_tx;
  logic [R_W-1:0] r_act;
  logic [N_W-1:0] n_act;
  logic ovl_w;
  logic rtick_w;
  logic wr_ok;
  logic restart_w;
  logic unlock_w;
  logic [CNT_W-1:0] lt_w;
  logic [CNT_W-1:0] et_w;
  logic latch_w;
  logic [1:0] preset_idx;

  assign pins = {freq_sel1_lock_pin_level, freq_sel0_serial_enable_pin,
                 pd_down, pd_up, vco_fb_clk, ref_osc_clk};
  assign tick = st_ff.sync2_ff & ~st_ff.prev_ff;
  assign mode_w = decode_mode(operating_mode_sel);
  // PLL idle reuses whichever pair was last in service
  assign use_tx = mode_w == PDLD_TX || (mode_w != PDLD_RX && st_ff.last_tx_ff);
  assign r_act = use_tx ? st_ff.tx_ref_ff : st_ff.rx_ref_ff;
  assign n_act = use_tx ? st_ff.tx_n_ff : st_ff.rx_n_ff;
  assign ovl_w = st_ff.sync2_ff[PIN_UP] && st_ff.sync2_ff[PIN_DN];
  assign rtick_w = tick[PIN_REF];
  assign wr_ok = st_ff.prog_ff && settings_wr;
  assign preset_idx = {st_ff.sync2_ff[PIN_FS1], st_ff.sync2_ff[PIN_FS0]};
  assign lt_w = st_ff.prog_ff ? lock_time_count : CNT_W'(DEF_LOCK_TIME);
  assign et_w = st_ff.prog_ff ? error_time_count : CNT_W'(DEF_ERR_TIME);
  assign latch_w = st_ff.prog_ff ? lock_latch_sel : DEF_LATCH;
  // A mode change into rx, tx or PLL idle, or a settings write in programmable mode, restarts the loop
  assign restart_w = wr_ok || (mode_w != st_ff.mode_ff && pll_on(mode_w))
                     || (st_ff.arm_ff != ARM_DONE);
  assign unlock_w = rtick_w && !ovl_w && st_ff.err_cnt_ff == '0;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1_ff = pins;
    nxt_st.sync2_ff = st_ff.sync1_ff;
    nxt_st.prev_ff = st_ff.sync2_ff;
    nxt_st.restart_ff = restart_w;
    nxt_st.mode_ff = mode_w;
    // Strap level is caught only once the synchroniser holds real data
    if (st_ff.arm_ff != ARM_DONE) begin
      nxt_st.arm_ff = st_ff.arm_ff + 2'h1;
      if (st_ff.arm_ff == ARM_CAP) begin
        nxt_st.fs0_ref_ff = st_ff.sync2_ff[PIN_FS0];
      end
    end else if (st_ff.sync2_ff[PIN_FS0] != st_ff.fs0_ref_ff) begin
      nxt_st.prog_ff = 1'b1;
    end
    if (mode_w == PDLD_RX) begin
      nxt_st.last_tx_ff = 1'b0;
    end else if (mode_w == PDLD_TX) begin
      nxt_st.last_tx_ff = 1'b1;
    end
    if (!st_ff.prog_ff) begin
      nxt_st.rx_ref_ff = SA_REF[preset_idx];
      nxt_st.rx_n_ff = SA_FB[preset_idx];
      nxt_st.tx_ref_ff = SA_REF[preset_idx];
      nxt_st.tx_n_ff = SA_FB[preset_idx];
      nxt_st.pump_ff = DEF_PUMP;
      nxt_st.pol_ff = DEF_POL;
      nxt_st.osc_start_ff = DEF_OSC_START;
      nxt_st.osc_steady_ff = DEF_OSC_STEADY;
      nxt_st.vco_cur_ff = DEF_VCO;
    end else begin
      if (settings_wr) begin
        nxt_st.rx_ref_ff = rx_ref_divider;
        nxt_st.rx_n_ff = rx_feedback_ratio;
        nxt_st.tx_ref_ff = tx_ref_divider;
        nxt_st.tx_n_ff = tx_feedback_ratio;
      end
      nxt_st.pump_ff = pump_current_sel;
      nxt_st.pol_ff = detector_polarity_bit;
      nxt_st.osc_start_ff = osc_startup_current;
      nxt_st.osc_steady_ff = osc_steady_current;
      nxt_st.vco_cur_ff = vco_current_sel;
    end
    nxt_st.amp_reg_ff = nxt_st.osc_start_ff != nxt_st.osc_steady_ff;
    nxt_st.invalid_ff = !ratio_ok(r_act, n_act);
    // Lock detection only makes sense while the synthesizer runs
    if (restart_w || !pll_on(mode_w)) begin
      nxt_st.lock_cnt_ff = lt_w;
      nxt_st.err_cnt_ff = et_w;
      nxt_st.lock_ind_ff = 1'b0;
    end else begin
      if (ovl_w) begin
        nxt_st.err_cnt_ff = et_w;
      end else if (rtick_w && st_ff.err_cnt_ff != '0) begin
        nxt_st.err_cnt_ff = st_ff.err_cnt_ff - CNT_ONE;
      end
      if (unlock_w) begin
        nxt_st.lock_cnt_ff = lt_w;
        if (latch_w) begin
          nxt_st.lock_ind_ff = 1'b0;
        end
      end else if (rtick_w && ovl_w) begin
        if (st_ff.lock_cnt_ff != '0) begin
          nxt_st.lock_cnt_ff = st_ff.lock_cnt_ff - CNT_ONE;
        end
        if (st_ff.lock_cnt_ff <= CNT_ONE) begin
          nxt_st.lock_ind_ff = 1'b1;
        end
      end
    end
    nxt_st.pin_oe_ff = nxt_st.prog_ff;
    nxt_st.pin_out_ff = nxt_st.prog_ff && nxt_st.lock_ind_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output rate is N times comparison rate once the loop settles
  pdld_ref_div i_pdld_ref_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ref_tick(rtick_w),
    .restart(st_ff.restart_ff),
    .ref_div(r_act),
    .ref_pulse(ref_cmp_pulse)
  );

  pdld_fb_div i_pdld_fb_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .vco_tick(tick[PIN_VCO]),
    .restart(st_ff.restart_ff),
    .ratio(n_act),
    .fb_pulse(fb_cmp_pulse)
  );

  assign programmable_mode = st_ff.prog_ff;
  assign lock_indication = st_ff.lock_ind_ff;
  assign freq_sel1_lock_pin = st_ff.pin_out_ff;
  assign freq_sel1_lock_pin_oe = st_ff.pin_oe_ff;
  assign pump_current = st_ff.pump_ff;
  assign detector_polarity = st_ff.pol_ff;
  assign osc_start_cur = st_ff.osc_start_ff;
  assign osc_steady_cur = st_ff.osc_steady_ff;
  assign amp_reg_en = st_ff.amp_reg_ff;
  assign vco_current = st_ff.vco_cur_ff;
  assign setting_invalid = st_ff.invalid_ff;

  ////////////////////////////////////////////////////////////////////////////
  lock_pin_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !st_ff.prog_ff |-> !freq_sel1_lock_pin_oe && !freq_sel1_lock_pin)
    else $error("lock pin driven in stand-alone mode");
  prog_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.prog_ff |=> st_ff.prog_ff)
    else $error("programmable mode was left");
  settings_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_ff.prog_ff && !settings_wr) |=> $stable(st_ff.rx_n_ff) && $stable(st_ff.tx_ref_ff))
    else $error("divider settings changed without a write");
  lock_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ovl_w |=> st_ff.lock_cnt_ff == $past(st_ff.lock_cnt_ff)
               || st_ff.lock_cnt_ff == $past(lt_w))
    else $error("lock counter moved without overlap");
  lock_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st_ff.lock_ind_ff) |-> $past(st_ff.lock_cnt_ff) <= CNT_ONE && $past(rtick_w && ovl_w))
    else $error("lock asserted before count completed");
  unlock_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (unlock_w && latch_w && pll_on(mode_w))
    |=> !st_ff.lock_ind_ff && st_ff.lock_cnt_ff == $past(lt_w))
    else $error("unlock did not reload the lock counter");
  err_reload_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ovl_w |=> st_ff.err_cnt_ff == $past(et_w))
    else $error("error counter not reloaded on overlap");
  latch_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_ff.lock_ind_ff && !latch_w && pll_on(mode_w) && !restart_w) |=> st_ff.lock_ind_ff)
    else $error("latched lock indication dropped");
  entry_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    restart_w |=> !st_ff.lock_ind_ff && !st_ff.pin_out_ff)
    else $error("lock indication survived a restart");
  idle_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (mode_w == PDLD_PLL_IDLE) |=> st_ff.last_tx_ff == $past(st_ff.last_tx_ff))
    else $error("idle mode changed the selected pair");
endmodule : pdld_synth

// *** tb/pdld_far_side.sv ***
module pdld_far_side (
  input wire logic clk_sys,
  input wire logic overlap_en,
  output logic ref_osc_clk,
  output logic vco_fb_clk,
  output logic pd_up,
  output logic pd_down
);
  timeunit 1ns;
  timeprecision 100ps;

  int ref_ph = 0;
  int vco_ph = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Crystal and VCO run free, so neither clock ever idles
  // Both phases stay above two system periods so no edge is lost
  always @(posedge clk_sys) begin
    ref_ph <= (ref_ph + 1) % 8;
    vco_ph <= (vco_ph + 1) % 6;
  end
  assign ref_osc_clk = (ref_ph < 4);
  assign vco_fb_clk = (vco_ph < 3);

  ////////////////////////////////////////////////////////////////////////////////
  // Up tracks the reference; down joins it only while the loop sits near lock
  assign pd_up = ref_osc_clk;
  assign pd_down = ref_osc_clk & overlap_en;
endmodule : pdld_far_side

// *** tb/test_pdld_synth.sv ***
module test_pdld_synth
  import pdld_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int S_LOCK = 0;
  localparam int S_PM = 1;
  localparam int S_PIN = 2;
  localparam int S_OE = 3;
  localparam int S_INV = 4;
  localparam int S_AMP = 5;
  localparam int S_PUMP = 6;
  localparam int S_POL = 7;
  localparam int S_VCO = 8;
  localparam int S_OSA = 9;
  localparam int S_OSB = 10;
  localparam int S_REF = 11;
  localparam int S_FB = 12;
  typedef struct {string what; int sel; logic [31:0] exp;} pdld_note_t;
  pdld_note_t notes[$];
  logic clk_sys, rst_n, ov_en, fs0, fs1_strap, fs1_wire, wr_en, latch, pol_sel;
  logic ref_osc_clk, vco_fb_clk, pd_up, pd_down;
  logic [2:0] op_mode;
  logic [R_W-1:0] rx_r, tx_r;
  logic [N_W-1:0] rx_n, tx_n;
  logic [CP_W-1:0] pump_sel, pump_current;
  logic [7:0] lock_t, err_t;
  logic [CUR_W-1:0] st_cur, sd_cur, vco_sel, osc_start_cur, osc_steady_cur, vco_current;
  logic ref_cmp_pulse, fb_cmp_pulse, programmable_mode, lock_indication;
  logic fs1_pin, fs1_oe, detector_polarity, amp_reg_en, setting_invalid;
  int error_cnt = 0;
  int compares = 0;
  int ref_cnt = 0;
  int fb_cnt = 0;
  int ref_gap = 0;
  int fb_gap = 0;
  int npl = 0;
  int a;
  int b;

  // Shared pin: the strap is seen only while the device is not driving it
  assign fs1_wire = fs1_oe ? fs1_pin : fs1_strap;

  pdld_far_side i_pdld_far_side (.clk_sys(clk_sys), .overlap_en(ov_en),
    .ref_osc_clk(ref_osc_clk), .vco_fb_clk(vco_fb_clk), .pd_up(pd_up), .pd_down(pd_down));

  pdld_synth #(.CNT_W(8)) i_pdld_synth (.clk_sys(clk_sys), .rst_n(rst_n),
    .ref_osc_clk(ref_osc_clk), .vco_fb_clk(vco_fb_clk), .pd_up(pd_up), .pd_down(pd_down),
    .freq_sel0_serial_enable_pin(fs0), .freq_sel1_lock_pin_level(fs1_wire),
    .operating_mode_sel(op_mode), .settings_wr(wr_en), .rx_ref_divider(rx_r),
    .rx_feedback_ratio(rx_n), .tx_ref_divider(tx_r), .tx_feedback_ratio(tx_n),
    .pump_current_sel(pump_sel), .detector_polarity_bit(pol_sel), .lock_time_count(lock_t),
    .error_time_count(err_t), .lock_latch_sel(latch), .osc_startup_current(st_cur),
    .osc_steady_current(sd_cur), .vco_current_sel(vco_sel), .ref_cmp_pulse(ref_cmp_pulse),
    .fb_cmp_pulse(fb_cmp_pulse), .programmable_mode(programmable_mode),
    .lock_indication(lock_indication), .freq_sel1_lock_pin(fs1_pin),
    .freq_sel1_lock_pin_oe(fs1_oe), .pump_current(pump_current),
    .detector_polarity(detector_polarity), .osc_start_cur(osc_start_cur),
    .osc_steady_cur(osc_steady_cur), .amp_reg_en(amp_reg_en), .vco_current(vco_current),
    .setting_invalid(setting_invalid));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // Watcher: a gap is judged between the 2nd and 3rd pulse so restarts settle first
  always @(negedge clk_sys) begin
    logic [31:0] seen;
    ref_cnt++;
    fb_cnt++;
    if (ref_cmp_pulse === 1'b1) begin
      ref_gap = ref_cnt;
      ref_cnt = 0;
    end
    if (fb_cmp_pulse === 1'b1) begin
      fb_gap = fb_cnt;
      fb_cnt = 0;
    end
    if (notes.size() != 0) begin
      if ((notes[0].sel == S_REF && ref_cmp_pulse === 1'b1) ||
          (notes[0].sel == S_FB && fb_cmp_pulse === 1'b1)) begin
        npl++;
      end
      if (notes[0].sel < S_REF || npl == 3) begin
        case (notes[0].sel)
          S_LOCK: seen = 32'(lock_indication);
          S_PM: seen = 32'(programmable_mode);
          S_PIN: seen = 32'(fs1_pin);
          S_OE: seen = 32'(fs1_oe);
          S_INV: seen = 32'(setting_invalid);
          S_AMP: seen = 32'(amp_reg_en);
          S_PUMP: seen = 32'(pump_current);
          S_POL: seen = 32'(detector_polarity);
          S_VCO: seen = 32'(vco_current);
          S_OSA: seen = 32'(osc_start_cur);
          S_OSB: seen = 32'(osc_steady_cur);
          S_REF: seen = 32'(ref_gap);
          default: seen = 32'(fb_gap);
        endcase
        check(notes[0].what, notes[0].exp, seen);
        void'(notes.pop_front());
        npl = 0;
      end
    end
  end

  task automatic note(input int n, input string what, input int sel, input logic [31:0] exp);
    int i;
    repeat (n) @(negedge clk_sys);
    notes.push_back('{what, sel, exp});
    for (i = 0; i < 4000 && notes.size() != 0; i++) begin
      @(negedge clk_sys);
    end
    if (notes.size() != 0) begin
      error_cnt++;
      $display("FAIL %s expected result never seen", what);
      notes.delete();
    end
  endtask : note

  task automatic wr(input logic [R_W-1:0] r, input logic [N_W-1:0] n);
    rx_r = r;
    rx_n = n;
    wr_en = 1'b1;
    @(negedge clk_sys);
    wr_en = 1'b0;
  endtask : wr

  task automatic wait_lock();
    int i;
    for (i = 0; i < 80 && lock_indication !== 1'b1; i++) begin
      @(negedge clk_sys);
    end
  endtask : wait_lock

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(60000 * 25);
    error_cnt++;
    complete_run();
  end

  initial begin
    {rst_n, ov_en, fs0, fs1_strap, wr_en, latch, pol_sel} = 7'h00;
    op_mode = 3'h1;
    {rx_r, tx_r, rx_n, tx_n} = '0;
    {pump_sel, lock_t, err_t, st_cur, sd_cur, vco_sel} = '0;
    void'($urandom(25650));
    pump_sel = CP_W'($urandom);
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    wr(10'h004, 17'h00040);
    note(0, "ref_gap", S_REF, 32'(SA_REF[0]) * 32'h8);
    note(0, "pump", S_PUMP, 32'(DEF_PUMP));
    note(0, "amp", S_AMP, 32'(DEF_OSC_START != DEF_OSC_STEADY));
    note(0, "osc_start", S_OSA, 32'(DEF_OSC_START));
    note(0, "osc_steady", S_OSB, 32'(DEF_OSC_STEADY));
    note(0, "oe", S_OE, 32'h0);
    note(0, "mode", S_PM, 32'h0);
    $display("test standalone done");
    fs0 = 1'b1;
    note(6, "mode", S_PM, 32'h1);
    note(0, "oe", S_OE, 32'h1);
    $display("test mode_switch done");
    tx_r = 10'h005;
    tx_n = 17'h00040;
    wr(10'h004, 17'h00040);
    note(0, "ref_gap", S_REF, 32'h20);
    note(0, "fb_gap", S_FB, 64 * 6);
    for (int k = 0; k < 3; k++) begin
      b = 4 + $urandom % 3;
      a = $urandom % b;
      wr(10'h004, {B_W'(b), A_W'(a)});
      note(0, "fb_gap", S_FB, (17 * a + 16 * (b - a)) * 6);
    end
    op_mode = 3'h2;
    note(0, "ref_gap", S_REF, 32'h28);
    op_mode = 3'h4;
    note(0, "ref_gap", S_REF, 32'h28);
    op_mode = 3'h1;
    note(0, "ref_gap", S_REF, 32'h20);
    $display("test dividers done");
    wr(10'h003, 17'h00040);
    note(2, "invalid", S_INV, 32'h1);
    wr(10'h004, 17'h00045);
    note(2, "invalid", S_INV, 32'h1);
    wr(10'h3FF, 17'h1FFFF);
    note(2, "invalid", S_INV, 32'h0);
    $display("test limits done");
    pol_sel = 1'b1;
    note(2, "pol", S_POL, 32'h1);
    pump_sel = CP_W'($urandom);
    pol_sel = 1'b0;
    vco_sel = 3'h0;
    st_cur = 3'h5;
    sd_cur = 3'h5;
    note(2, "pump", S_PUMP, 32'(pump_sel));
    note(0, "pol", S_POL, 32'h0);
    note(0, "vco", S_VCO, 32'h0);
    note(0, "amp", S_AMP, 32'h0);
    sd_cur = 3'h1;
    note(2, "amp", S_AMP, 32'h1);
    note(0, "osc_start", S_OSA, 32'h5);
    note(0, "osc_steady", S_OSB, 32'h1);
    $display("test config done");
    lock_t = 8'h03;
    err_t = 8'h02;
    latch = 1'b1;
    wr(10'h004, 17'h00040);
    ov_en = 1'b1;
    note(16, "lock", S_LOCK, 32'h0);
    wait_lock();
    note(0, "lock", S_LOCK, 32'h1);
    note(0, "pin", S_PIN, 32'h1);
    ov_en = 1'b0;
    note(8, "lock", S_LOCK, 32'h1);
    note(48, "lock", S_LOCK, 32'h0);
    latch = 1'b0;
    ov_en = 1'b1;
    wait_lock();
    ov_en = 1'b0;
    note(64, "lock", S_LOCK, 32'h1);
    wr(10'h004, 17'h00040);
    note(2, "lock", S_LOCK, 32'h0);
    op_mode = 3'h0;
    ov_en = 1'b1;
    note(40, "lock", S_LOCK, 32'h0);
    op_mode = 3'h3;
    note(40, "lock", S_LOCK, 32'h0);
    op_mode = 3'h7;
    note(40, "lock", S_LOCK, 32'h0);
    $display("test lock done");
    // Strap unchanged across reset, so the device must come back stand-alone
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    note(0, "mode", S_PM, 32'h0);
    note(0, "oe", S_OE, 32'h0);
    note(2, "pump", S_PUMP, 32'(DEF_PUMP));
    note(8, "mode", S_PM, 32'h0);
    $display("test reset done");
    complete_run();
  end
endmodule : test_pdld_synth
